//--- branch_target_cache_control_tb.sv
// self-checking bench for the branch target cache control block
// assumes btc_flash_model as flash and btc_control_props bound to the design
`timescale 1ns/1ps
module branch_target_cache_control_tb;
	logic        mclk = 1'b0, rst_n = 1'b0, sfrWrEn = 1'b0, sfrRdEn = 1'b0, fetchReq = 1'b0;
	logic        fetchTable = 1'b0, fetchRetiTarget = 1'b0, fetchInIsr = 1'b0;
	logic        flashBusyIn = 1'b0, flashInvValid = 1'b0, swWrReq = 1'b0;
	logic [7:0]  sfrAddr = 8'h00, sfrWrData = 8'h00, swWrData = 8'h00;
	logic [15:0] fetchAddr = 16'h0000, flashInvAddr = 16'h0000, swWrAddr = 16'h0000;
	logic [3:0]  lat = 4'h1, flashWrMask;
	logic [7:0]  sfrRdData, fetchData;
	logic        fetchDone, coreStall, prefetchEnable, flashRdReq, flashRdValid, flashWrStrobe;
	logic [12:0] flashRdAddr;
	logic [13:0] flashWrAddr;
	logic [31:0] flashRdData, flashWrData, bw, seed = 32'hB7F47367;
	int          fails = 0, cmp_count = 0, pen = 0, ctrl = 8'hE6, th = 0, push = 0;
	bit          cached [int];
	btc_control u_dut (.mclk, .rst_n, .sfrAddr, .sfrWrEn, .sfrRdEn, .sfrWrData, .sfrRdData,
		.fetchReq, .fetchAddr, .fetchTable, .fetchRetiTarget, .fetchInIsr, .fetchData,
		.fetchDone, .coreStall, .prefetchEnable, .flashRdReq, .flashRdAddr, .flashRdValid,
		.flashRdData, .flashBusyIn, .flashInvValid, .flashInvAddr, .swWrReq, .swWrAddr,
		.swWrData, .flashWrStrobe, .flashWrAddr, .flashWrData, .flashWrMask);
	btc_flash_model u_flash (.mclk, .flashRdReq, .flashRdAddr, .lat, .flashRdValid, .flashRdData);
	// ****
	// helpers
	// ****
	// free running clock
	always #20 mclk = ~mclk;
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(logic [39:0] e, logic [39:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("mismatch at %0t: expected %h, got %h", $time, e, g);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge mclk);
		sfrAddr <= a;
		sfrWrData <= d;
		sfrWrEn <= 1'b1;
		@(posedge mclk);
		sfrWrEn <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		sfrAddr <= a;
		sfrRdEn <= 1'b1;
		@(posedge mclk);
		sfrRdEn <= 1'b0;
		#1 d = sfrRdData;
	endtask
	task automatic rdc(logic [7:0] a, logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk(e, d);
	endtask
	// accumulator seen as overflow, then bits 11 to 1
	task automatic pchk();
		logic [7:0] d;
		logic [7:0] e;
		rd(8'hD3, d);
		rd(8'hC9, e);
		chk({pen > 4095, 11'(pen >> 1)}, {d, e[7:4]});
	endtask
	task automatic inv(logic [15:0] a);
		@(posedge mclk);
		flashInvAddr <= a;
		flashInvValid <= 1'b1;
		@(posedge mclk);
		flashInvValid <= 1'b0;
		cached.delete(a[15:3]);
	endtask
	// one fetch, f holds table, return target and service routine flags
	task automatic fx(logic [15:0] a, logic [2:0] f);
		int n;
		logic [31:0] w;
		bit hit;
		bit ex;
		n = 0;
		w = {3'h5, a[15:3], 3'h2, a[15:3]};
		hit = ctrl[6] && cached.exists(a[15:3]) && !(push && f[2]);
		ex = (f[2] && !ctrl[1]) || (f[1] && !ctrl[3]) || (f[0] && !ctrl[2]);
		@(posedge mclk);
		fetchAddr <= a;
		{fetchTable, fetchRetiTarget, fetchInIsr} <= f;
		fetchReq <= 1'b1;
		lat <= 4'(rnd() & 32'h7) + 4'h1;
		@(posedge mclk);
		fetchReq <= 1'b0;
		#1;
		for (int i = 0; i < 40 && fetchDone !== 1'b1; i++) begin
			n += int'(coreStall === 1'b1);
			@(posedge mclk);
			#1;
		end
		if (fetchDone !== 1'b1) begin
			fails++;
			$display("mismatch at %0t: expected %h, got %h", $time, 1'b1, fetchDone);
			finish_test();
		end
		chk(!hit, n != 0);
		chk((w >> (8 * a[1:0])) & 32'hFF, fetchData);
		pen += n;
		if ((push && f[2]) || (ctrl[7] && n > th && !ex)) begin
			cached[a[15:3]] = 1'b1;
		end
	endtask
	task automatic sw(logic [15:0] a, bit blk);
		logic [7:0] d;
		d = 8'(rnd());
		bw[8 * a[1:0] +: 8] = d;
		@(posedge mclk);
		swWrAddr <= a;
		swWrData <= d;
		swWrReq <= 1'b1;
		@(posedge mclk);
		swWrReq <= 1'b0;
		#1;
		chk(!blk || a[1:0] == 2'h3, flashWrStrobe);
		if (flashWrStrobe === 1'b1) begin
			chk(a[15:2], flashWrAddr);
			chk(blk ? {bw, 4'hF} : {{4{d}}, 4'(1 << a[1:0])}, {flashWrData, flashWrMask});
		end
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		logic [31:0] r;
		logic [7:0]  ra [6];
		logic [7:0]  rv [6];
		ra = '{8'h84, 8'hC9, 8'hD2, 8'hD3, 8'hAC, 8'h90};
		rv = '{8'hE6, 8'h04, 8'h1F, 8'h00, 8'h00, 8'h00};
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		wr(8'hAC, 8'hFF);
		wr(8'hD2, 8'h20);
		wr(8'h90, 8'hFF);
		for (int i = 0; i < 6; i++) rdc(ra[i], rv[i]);
		$display("test registers done");
		for (int k = 0; k < 16; k++) begin
			r = rnd();
			ctrl = r & 32'hFE;
			th = r[9:8];
			wr(8'h84, 8'(ctrl));
			rdc(8'h84, 8'(ctrl) & 8'hEF);
			if (ctrl[4]) cached.delete();
			wr(8'hC9, {6'h00, r[9:8]});
			fx({r[11:10], 11'h155, r[14:12]}, r[18:16] & r[21:19]);
			if (r[23:22] == 2'h0) inv({r[11:10], 11'h155, r[14:12]});
		end
		pchk();
		$display("test fetch done");
		ctrl = 8'hE6;
		wr(8'h84, 8'hE6);
		wr(8'hD2, 8'h80);
		push = 1;
		fx(16'h2468, 3'h4);
		rdc(8'hD2, 8'h9E);
		wr(8'hD2, 8'h40);
		push = 0;
		rdc(8'hD2, 8'h1F);
		fx(16'h2468, 3'h4);
		$display("test lock done");
		// fixed slot: a second table read evicts the first from slot zero
		wr(8'h84, 8'hF6);
		cached.delete();
		th = 0;
		wr(8'hC9, 8'h04);
		fx(16'h5A00, 3'h4);
		fx(16'h5B00, 3'h4);
		cached.delete(16'h5A00 >> 3);
		fx(16'h5A00, 3'h0);
		// pseudo-random policy still fills a replaceable slot
		wr(8'hC9, 8'h08);
		fx(16'h6C00, 3'h0);
		fx(16'h6C00, 3'h0);
		$display("test policy done");
		for (int m = 0; m < 2; m++) begin
			wr(8'h84, 8'hE6 | 8'(m));
			for (int i = 0; i < 4; i++) sw(16'h3A50 + 16'(i), m[0]);
		end
		$display("test flash write done");
		for (int b = 1; b >= 0; b--) begin
			@(posedge mclk);
			flashBusyIn <= b[0];
			repeat (3) @(posedge mclk);
			rdc(8'hAC, {7'h00, b[0]});
		end
		$display("test busy done");
		wr(8'hD3, 8'hFF);
		pen = 12'hFE0;
		pchk();
		ctrl = 8'h26;
		wr(8'h84, 8'h26);
		for (int i = 0; i < 60 && pen < 4100; i++) fx(16'h4000 + 16'(i * 8), 3'h0);
		pchk();
		wr(8'hD3, 8'h00);
		pen = 0;
		pchk();
		$display("test penalty done");
		finish_test();
	end
endmodule

//--- btc_cfg.svh
// constants for the branch target cache control block
// assumes an 8-bit special function register port and a 25 MHz mclk
`ifndef BTC_CFG_SVH
`define BTC_CFG_SVH
// register addresses
`define BTC_ADDR_CTRL    8'h84
`define BTC_ADDR_FSTAT   8'hAC
`define BTC_ADDR_TUNE    8'hC9
`define BTC_ADDR_LOCK    8'hD2
`define BTC_ADDR_PENALTY 8'hD3
// reset values
`define BTC_RST_CTRL     8'hE6
`define BTC_RST_TUNE     8'h04
`define BTC_RST_LOCK     8'h1F
`define BTC_RST_PENALTY  12'h000
// control register bits
`define BTC_CTRL_WREN    7
`define BTC_CTRL_RDEN    6
`define BTC_CTRL_PFEN    5
`define BTC_CTRL_FLUSH   4
`define BTC_CTRL_INTERRUPT_RETURN    3
`define BTC_CTRL_ISR     2
`define BTC_CTRL_TABLE   1
`define BTC_CTRL_BLKW    0
// tuning and lock register bits
`define BTC_TUNE_ALG     3
`define BTC_TUNE_FIX     2
`define BTC_LOCK_PUSH    7
`define BTC_LOCK_POP     6
// cache geometry and counter limits
`define BTC_SLOTS        32
`define BTC_SLOT_LAST    5'h1F
`define BTC_PEN_MAX      12'hFFF
`define BTC_STALL_MAX    3'h7
`define BTC_LFSR_SEED    5'h15
`endif

//--- btc_control.sv
// branch target cache with its control, tuning, lock stack and miss statistics
// assumes single-cycle sfr strobes and a flash reader that answers with one word
// Overview of operation
// - cache fills on misses only when write enable set; pushes and invalidation always act
// - read enable low forces every fetch to flash; high lets hits answer
// - prefetch engine enable output follows the prefetch enable bit
// - writing one to flush clears all valid bits; flush reads zero
// - interrupt return targets are cached only when their caching bit is set
// - service routine code is cached only when its caching bit is set
// - table read data is cached only when table read caching is set or push is enabled
// - block write mode commits four bytes together, otherwise each byte alone
// - registers reset to E6, 04, 1F and flash status 00
// - policy select zero picks bounce order, one picks pseudo-random
// - fixed slot bit sends every cached table read segment to slot zero unless push is enabled
// - a non-push miss is cached only when its stall exceeds the threshold field
// - with push enabled a table read locks its segment at pointer, then decrements
// - writing one to pop increments the pointer; pop reads zero
// - slots above the pointer are never replaced, unless the pointer is zero
// - the penalty accumulator counts every cycle the core stalls on a miss, except a cycle that writes the high field
// - overflow flag sets on accumulator wrap and holds until the next write
// - reading the high field snapshots accumulator bits four to one into tuning
// - writing the high field clears the lowest five accumulator bits
// - accumulator bit zero stays hidden so readings count pairs of cycles
// - flash busy reads one while a write or erase is in progress
// - bounce order walks slots upward to the last, then back down
// - flash write or erase invalidates affected cached segments unconditionally
`timescale 1ns/1ps
`include "btc_cfg.svh"

module btc_control (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  sfrAddr,
	input  wire logic        sfrWrEn,
	input  wire logic        sfrRdEn,
	input  wire logic [7:0]  sfrWrData,
	output logic      [7:0]  sfrRdData,
	input  wire logic        fetchReq,
	input  wire logic [15:0] fetchAddr,
	input  wire logic        fetchTable,
	input  wire logic        fetchRetiTarget,
	input  wire logic        fetchInIsr,
	output logic      [7:0]  fetchData,
	output logic             fetchDone,
	output logic             coreStall,
	output logic             prefetchEnable,
	output logic             flashRdReq,
	output logic      [12:0] flashRdAddr,
	input  wire logic        flashRdValid,
	input  wire logic [31:0] flashRdData,
	input  wire logic        flashBusyIn,
	input  wire logic        flashInvValid,
	input  wire logic [15:0] flashInvAddr,
	input  wire logic        swWrReq,
	input  wire logic [15:0] swWrAddr,
	input  wire logic [7:0]  swWrData,
	output logic             flashWrStrobe,
	output logic      [13:0] flashWrAddr,
	output logic      [31:0] flashWrData,
	output logic      [3:0]  flashWrMask
);
	// ***********************************
	// storage and state
	// ***********************************
	logic [7:0]          ctrl_q;
	logic [3:0]          tuneLow_q;
	logic [3:0]          penaltyLow_q;
	logic                pushEn_q;
	btc_pkg::btc_slot_t  slotPtr_q;
	logic [11:0]         penalty_q;
	logic                overflow_q;
	logic                flashBusy_q;
	btc_pkg::btc_state_e state_q;
	btc_pkg::btc_tag_t   reqTag_q;
	logic [1:0]          reqOff_q;
	logic                reqTable_q;
	logic                reqExcl_q;
	logic [2:0]          stallCnt_q;
	btc_pkg::btc_slot_t  bounceIdx_q;
	logic                bounceDown_q;
	logic [4:0]          lfsr_q;
	logic [31:0]         wrBuf_q;
	logic [3:0]          wrMask_q;
	logic [31:0]         dataMem [`BTC_SLOTS];
	btc_pkg::btc_tag_t   tagMem  [`BTC_SLOTS];
	logic [`BTC_SLOTS-1:0] valid;
	logic [`BTC_SLOTS-1:0] hitVec;
	logic [`BTC_SLOTS-1:0] invVec;

	// ***********************************
	// register port decode
	// ***********************************
	logic wrCtrl, wrTune, wrLock, wrPenalty, rdPenalty;
	assign wrCtrl    = sfrWrEn && (sfrAddr == `BTC_ADDR_CTRL);
	assign wrTune    = sfrWrEn && (sfrAddr == `BTC_ADDR_TUNE);
	assign wrLock    = sfrWrEn && (sfrAddr == `BTC_ADDR_LOCK);
	assign wrPenalty = sfrWrEn && (sfrAddr == `BTC_ADDR_PENALTY);
	assign rdPenalty = sfrRdEn && (sfrAddr == `BTC_ADDR_PENALTY);

	logic flushNow, popNow;
	assign flushNow = wrCtrl && sfrWrData[`BTC_CTRL_FLUSH];
	assign popNow   = wrLock && sfrWrData[`BTC_LOCK_POP];

	// ***********************************
	// lookup
	// ***********************************
	btc_pkg::btc_tag_t fetchTag;
	assign fetchTag = fetchAddr[15:3] ^ 13'h0000;

	// two comparators per slot, one for hits and one for flash invalidation
	genvar gi;
	generate
		for (gi = 0; gi < `BTC_SLOTS; gi++) begin : gSlot
			assign hitVec[gi] = valid[gi] && (tagMem[gi] == fetchAddr[15:3]);
			assign invVec[gi] = valid[gi] && (tagMem[gi] == flashInvAddr[15:3]);
		end
	endgenerate

	// hit slot encoder
	btc_pkg::btc_slot_t hitIdx;
	always_comb begin
		hitIdx = 5'h00;
		for (int i = 0; i < `BTC_SLOTS; i++) begin
			if (hitVec[i]) begin
				hitIdx = 5'(i);
			end
		end
	end

	logic hitNow;
	assign hitNow = ctrl_q[`BTC_CTRL_RDEN] && (|hitVec);

	// ***********************************
	// fill decision and victim choice
	// ***********************************
	btc_pkg::btc_slot_t limit, bounceSlot, randSlot, fillSlot;
	logic [2:0] stallNext;
	logic       fillDone, pushOp, normalFill, doFill;

	// highest replaceable slot; pointer zero unlocks everything
	assign limit      = (slotPtr_q == 5'h00) ? `BTC_SLOT_LAST : slotPtr_q;
	assign bounceSlot = (bounceIdx_q > limit) ? limit : bounceIdx_q;
	assign randSlot   = (lfsr_q > limit) ? limit : lfsr_q;
	assign stallNext  = (stallCnt_q == `BTC_STALL_MAX) ? stallCnt_q : stallCnt_q + 3'h1;
	assign fillDone   = (state_q == btc_pkg::BTC_MISS) && flashRdValid;
	assign pushOp     = reqTable_q && pushEn_q;
	// normal fills need write enable, eligibility and a long enough stall
	assign normalFill = ctrl_q[`BTC_CTRL_WREN] && !reqExcl_q
		&& ({1'b0, stallNext} > {1'b0, tuneLow_q[1:0] ^ 2'h0});
	assign doFill     = fillDone && (pushOp || normalFill) && !flushNow;

	always_comb begin
		if (pushOp) begin
			fillSlot = slotPtr_q;
		end else if (reqTable_q && tuneLow_q[`BTC_TUNE_FIX]) begin
			fillSlot = 5'h00;
		end else if (tuneLow_q[`BTC_TUNE_ALG]) begin
			fillSlot = randSlot;
		end else begin
			fillSlot = bounceSlot;
		end
	end

	// ***********************************
	// cache arrays
	// ***********************************
	// per-slot valid bits; flush and flash changes win over a fill
	generate
		for (gi = 0; gi < `BTC_SLOTS; gi++) begin : gValid
			always_ff @(posedge mclk) begin
				if (!rst_n || flushNow) begin
					valid[gi] <= 1'b0;
				end else if (flashInvValid && invVec[gi]) begin
					valid[gi] <= 1'b0;
				end else if (doFill && (fillSlot == 5'(gi))) begin
					valid[gi] <= !(flashInvValid && (flashInvAddr[15:3] == reqTag_q));
				end
			end
		end
	endgenerate

	// tag and data words are written with each fill
	always_ff @(posedge mclk) begin
		if (doFill) begin
			tagMem[fillSlot]  <= reqTag_q;
			dataMem[fillSlot] <= flashRdData;
		end
	end

	// ***********************************
	// fetch sequencer
	// ***********************************
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_q     <= btc_pkg::BTC_IDLE;
			fetchData   <= 8'h00;
			fetchDone   <= 1'b0;
			coreStall   <= 1'b0;
			flashRdReq  <= 1'b0;
			flashRdAddr <= 13'h0000;
			reqTag_q    <= 13'h0000;
			reqOff_q    <= 2'h0;
			reqTable_q  <= 1'b0;
			reqExcl_q   <= 1'b0;
			stallCnt_q  <= 3'h0;
		end else begin
			fetchDone  <= 1'b0;
			flashRdReq <= 1'b0;
			case (state_q)
				btc_pkg::BTC_IDLE: begin
					// a push always reads flash so the segment can be locked
					if (fetchReq && hitNow && !(fetchTable && pushEn_q)) begin
						fetchData <= dataMem[hitIdx][8*fetchAddr[1:0] +: 8];
						fetchDone <= 1'b1;
					end else if (fetchReq) begin
						state_q     <= btc_pkg::BTC_MISS;
						coreStall   <= 1'b1;
						flashRdReq  <= 1'b1;
						flashRdAddr <= fetchTag;
						reqTag_q    <= fetchTag;
						reqOff_q    <= fetchAddr[1:0];
						reqTable_q  <= fetchTable;
						reqExcl_q   <= (fetchRetiTarget && !ctrl_q[`BTC_CTRL_INTERRUPT_RETURN])
							|| (fetchInIsr && !ctrl_q[`BTC_CTRL_ISR])
							|| (fetchTable && !ctrl_q[`BTC_CTRL_TABLE]);
						stallCnt_q  <= 3'h0;
					end
				end
				btc_pkg::BTC_MISS: begin
					stallCnt_q <= stallNext;
					if (flashRdValid) begin
						state_q   <= btc_pkg::BTC_IDLE;
						coreStall <= 1'b0;
						fetchData <= flashRdData[8*reqOff_q +: 8];
						fetchDone <= 1'b1;
					end
				end
				default: begin
					state_q   <= btc_pkg::BTC_IDLE;
					coreStall <= 1'b0;
				end
			endcase
		end
	end

	// ***********************************
	// replacement state
	// ***********************************
	// bounce walker advances on each non-push fill in bounce order; the random source steps every cycle
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			bounceIdx_q  <= 5'h00;
			bounceDown_q <= 1'b0;
			lfsr_q       <= `BTC_LFSR_SEED;
		end else begin
			lfsr_q <= {lfsr_q[3:0], lfsr_q[4] ^ lfsr_q[2]};
			if (doFill && !pushOp && !tuneLow_q[`BTC_TUNE_ALG]) begin
				if (!bounceDown_q && (bounceSlot >= limit)) begin
					bounceDown_q <= 1'b1;
					bounceIdx_q  <= limit - 5'h01;
				end else if (!bounceDown_q) begin
					bounceIdx_q <= bounceSlot + 5'h01;
				end else if (bounceSlot == 5'h00) begin
					bounceDown_q <= 1'b0;
					bounceIdx_q  <= 5'h01;
				end else begin
					bounceIdx_q <= bounceSlot - 5'h01;
				end
			end
		end
	end

	// ***********************************
	// control and tuning registers
	// ***********************************
	// flush bit is not stored so it reads as zero
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ctrl_q    <= `BTC_RST_CTRL;
			tuneLow_q <= 4'(`BTC_RST_TUNE);
		end else begin
			if (wrCtrl) begin
				ctrl_q <= sfrWrData & ~(8'h01 << `BTC_CTRL_FLUSH);
			end
			if (wrTune) begin
				tuneLow_q <= sfrWrData[3:0];
			end
		end
	end

	assign prefetchEnable = ctrl_q[`BTC_CTRL_PFEN];

	// ***********************************
	// lock stack
	// ***********************************
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pushEn_q  <= 1'b0;
			slotPtr_q <= 5'(`BTC_RST_LOCK);
		end else begin
			if (wrLock) begin
				pushEn_q <= sfrWrData[`BTC_LOCK_PUSH];
			end
			if (popNow) begin
				slotPtr_q <= slotPtr_q + 5'h01;
			end else if (doFill && pushOp) begin
				slotPtr_q <= slotPtr_q - 5'h01;
			end
		end
	end

	// ***********************************
	// miss penalty accumulator
	// ***********************************
	// a write blocks that cycle's increment, so a wrap never meets the clear
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			penalty_q    <= `BTC_RST_PENALTY;
			overflow_q   <= 1'b0;
			penaltyLow_q <= 4'h0;
		end else begin
			if (wrPenalty) begin
				penalty_q <= {sfrWrData[6:0], 5'h00};
			end else if (coreStall) begin
				penalty_q <= penalty_q + 12'h001;
			end
			if (coreStall && !wrPenalty && (penalty_q == `BTC_PEN_MAX)) begin
				overflow_q <= 1'b1;
			end else if (wrPenalty) begin
				overflow_q <= 1'b0;
			end
			if (rdPenalty) begin
				penaltyLow_q <= penalty_q[4:1];
			end else if (wrTune) begin
				penaltyLow_q <= sfrWrData[7:4];
			end
		end
	end

	// ***********************************
	// flash status and software flash writes
	// ***********************************
	// partial groups wait for the fourth byte in block mode
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			flashBusy_q   <= 1'b0;
			wrBuf_q       <= 32'h00000000;
			wrMask_q      <= 4'h0;
			flashWrStrobe <= 1'b0;
			flashWrAddr   <= 14'h0000;
			flashWrData   <= 32'h00000000;
			flashWrMask   <= 4'h0;
		end else begin
			flashBusy_q   <= flashBusyIn;
			flashWrStrobe <= 1'b0;
			if (swWrReq && ctrl_q[`BTC_CTRL_BLKW]) begin
				wrBuf_q[8*swWrAddr[1:0] +: 8] <= swWrData;
				wrMask_q[swWrAddr[1:0]]       <= 1'b1;
				if (swWrAddr[1:0] == 2'h3) begin
					flashWrStrobe <= 1'b1;
					flashWrAddr   <= swWrAddr[15:2];
					flashWrData   <= {swWrData, wrBuf_q[23:0]};
					flashWrMask   <= wrMask_q | 4'h8;
					wrMask_q      <= 4'h0;
				end
			end else if (swWrReq) begin
				flashWrStrobe <= 1'b1;
				flashWrAddr   <= swWrAddr[15:2];
				flashWrData   <= {4{swWrData}};
				flashWrMask   <= 4'h1 << swWrAddr[1:0];
			end
		end
	end

	// ***********************************
	// register readback
	// ***********************************
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sfrRdData <= 8'h00;
		end else if (sfrRdEn) begin
			case (sfrAddr)
				`BTC_ADDR_CTRL:    sfrRdData <= ctrl_q;
				`BTC_ADDR_TUNE:    sfrRdData <= {penaltyLow_q, tuneLow_q};
				`BTC_ADDR_LOCK:    sfrRdData <= {pushEn_q, 2'b00, slotPtr_q};
				`BTC_ADDR_PENALTY: sfrRdData <= {overflow_q, penalty_q[11:5]};
				`BTC_ADDR_FSTAT:   sfrRdData <= {7'h00, flashBusy_q};
				default:           sfrRdData <= 8'h00;
			endcase
		end
	end
endmodule

//--- btc_control_props.sv
// port assertions for btc_control
// assumes the port names and widths of btc_control, bound below
`timescale 1ns/1ps
module btc_control_props (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic [7:0]  sfrAddr,
	input wire logic        sfrWrEn,
	input wire logic        sfrRdEn,
	input wire logic [7:0]  sfrWrData,
	input wire logic [7:0]  sfrRdData,
	input wire logic        fetchDone,
	input wire logic        coreStall,
	input wire logic        prefetchEnable,
	input wire logic        flashRdReq,
	input wire logic        flashRdValid,
	input wire logic        flashBusyIn,
	input wire logic        swWrReq,
	input wire logic [15:0] swWrAddr,
	input wire logic        flashWrStrobe,
	input wire logic [13:0] flashWrAddr
);
	// ****
	// port relations
	// ****
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	// register strobes
	wire ctlWr = sfrWrEn && sfrAddr == 8'h84;
	wire statRd = sfrRdEn && sfrAddr == 8'hAC;
	pfen_follow_a: assert property (
		ctlWr ##1 !ctlWr |=> prefetchEnable == $past(sfrWrData[5], 2))
		else $error("prefetch enable differs from control bit");
	flush_reads_zero_a: assert property (
		sfrRdEn && sfrAddr == 8'h84 |=> !sfrRdData[4])
		else $error("flush bit read as one");
	lock_bits_zero_a: assert property (
		sfrRdEn && sfrAddr == 8'hD2 |=> sfrRdData[6:5] == 2'h0)
		else $error("pop or reserved lock bit read as one");
	status_read_a: assert property (
		statRd && $past(rst_n) && $stable(flashBusyIn) |=> sfrRdData == {7'h00, $past(flashBusyIn)})
		else $error("flash status read wrong");
	miss_start_a: assert property (
		$rose(coreStall) |-> flashRdReq)
		else $error("stall began without a flash read");
	stall_hold_a: assert property (
		coreStall && !flashRdValid |=> coreStall)
		else $error("stall ended before flash answered");
	stall_end_a: assert property (
		coreStall && flashRdValid |=> fetchDone && !coreStall)
		else $error("miss not answered after flash data");
	word_commit_a: assert property (
		swWrReq && swWrAddr[1:0] == 2'h3 |=> flashWrStrobe && flashWrAddr == $past(swWrAddr[15:2]))
		else $error("last byte of a word not committed");
	miss_seen_c: cover property (flashRdReq);
	hit_seen_c: cover property (fetchDone && !$past(coreStall));
	acc_write_c: cover property (sfrWrEn && sfrAddr == 8'hD3);
	wr_commit_c: cover property (swWrReq ##1 flashWrStrobe);
endmodule
bind btc_control btc_control_props u_props (
	.mclk, .rst_n, .sfrAddr, .sfrWrEn, .sfrRdEn, .sfrWrData, .sfrRdData, .fetchDone,
	.coreStall, .prefetchEnable, .flashRdReq, .flashRdValid, .flashBusyIn, .swWrReq,
	.swWrAddr, .flashWrStrobe, .flashWrAddr
);

//--- btc_flash_model.sv
// flash word reader standing behind the cache control block
// assumes one read outstanding at a time, answered lat cycles later
`timescale 1ns/1ps
module btc_flash_model (
	input  wire logic        mclk,
	input  wire logic        flashRdReq,
	input  wire logic [12:0] flashRdAddr,
	input  wire logic [3:0]  lat,
	output logic             flashRdValid,
	output logic      [31:0] flashRdData
);
	// ****
	// read pipe
	// ****
	int          cnt = 0;
	logic [12:0] wordIdx = 13'h0000;
	initial flashRdValid = 1'b0;
	initial flashRdData = 32'h00000000;
	// count the latency down, data toggles outside the answer cycle
	always @(posedge mclk) begin
		flashRdValid <= 1'b0;
		flashRdData <= ~flashRdData;
		if (flashRdReq) begin
			cnt <= lat;
			wordIdx <= flashRdAddr;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
		end
		if (!flashRdReq && cnt == 1) begin
			flashRdValid <= 1'b1;
			flashRdData <= {3'h5, wordIdx, 3'h2, wordIdx};
		end
	end
endmodule

//--- btc_pkg.sv
// types shared by the branch target cache control block
// assumes btc_cfg.svh holds the numeric constants
package btc_pkg;
	typedef enum logic [0:0] {
		BTC_IDLE = 1'b0,
		BTC_MISS = 1'b1
	} btc_state_e;
	typedef logic [4:0]  btc_slot_t;
	typedef logic [12:0] btc_tag_t;
endpackage
